// [verilog/sebsw_slave.v]
/*
 * sebsw_slave.v: two-wire bus slave front end of a 64-kbit serial EEPROM:
 * start/stop detection, bit and acknowledge framing, control byte decode,
 * word addressing, byte/page write buffering with write protection, a timed
 * write cycle that streams committed bytes out through a fifo, and reads.
 * Assumes scl, sda, chip select and protect pins are asynchronous to clk_sys_in
 * and much slower than it; rd_data_in answers rd_addr_out within a few clocks;
 * the array behind prog_* drains the stream.
 */
`timescale 1ns/1ps
`include "sebsw_defines.vh"

// Behaviour
// - with protect pin high, writes to 1800h-1fffh are blocked; reads unaffected.
// - data falling while clock high is a start.
// - data rising while clock high is a stop.
// - every received byte is acknowledged in a ninth clock pulse.
// - acknowledger holds data low through the acknowledge clock high phase.
// - master withholds final read acknowledge; device then releases data.
// - no acknowledge at all while the internal write cycle runs.
// - first byte after start is control: type code, chip selects, direction.
// - respond only when chip select bits equal the chip select pins.
// - direction one selects read, zero selects write.
// - write takes high then low address byte, 13-bit word address.
// - sequential read wraps inside own memory, never into another device.
// - byte write starts its write cycle at the master's stop.
// - protected write is acknowledged, not stored, new command accepted at once.
// - after byte write the pointer holds the next location.
// - page write buffers up to 32 bytes, committed only after stop.
// - each page data byte increments only the low five pointer bits.
// - beyond 32 bytes the pointer wraps, keeping only the last 32.
// - page write wraps at its page end, never into the next page.
// - protect pin sampled at every write stop; later changes are ignored.
// - the write cycle finishes within at most 5 ms.
module sebsw_slave #(
  parameter [3:0] DEV_TYPE_CODE = 4'h5,  // arbitrary value, set per product
  parameter       TWC_CYCLES    = `SEBSW_TWC_MS * (`SEBSW_CLK_HZ / `SEBSW_MS_DIV)
) (
  input  wire                      clk_sys_in,
  input  wire                      srst_in,
  input  wire                      scl_in,
  input  wire                      sda_in,
  output wire                      sda_out,
  output wire                      sda_oe_out,
  input  wire                      chip_select_bit0_in,
  input  wire                      chip_select_bit1_in,
  input  wire                      chip_select_bit2_in,
  input  wire                      wp_in,
  output wire [`SEBSW_ADDR_W-1:0]  rd_addr_out,
  input  wire [7:0]                rd_data_in,
  output wire                      prog_valid_out,
  input  wire                      prog_ready_in,
  output wire [`SEBSW_ADDR_W-1:0]  prog_addr_out,
  output wire [7:0]                prog_data_out,
  output wire                      busy_out
);

  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_CTRL  = 7'h02;
  localparam [6:0] S_ADRH  = 7'h04;
  localparam [6:0] S_ADRL  = 7'h08;
  localparam [6:0] S_WDATA = 7'h10;
  localparam [6:0] S_RDATA = 7'h20;
  localparam [6:0] S_IGN   = 7'h40;

  // last timer count, cut to the timer width on purpose
  localparam integer            TWC_LAST_I = TWC_CYCLES - 1;
  localparam [`SEBSW_TMR_W-1:0] TWC_LAST   = TWC_LAST_I[`SEBSW_TMR_W-1:0];

  // pointer step: page mode keeps the page bits, read mode rolls the whole word
  function [`SEBSW_ADDR_W-1:0] next_addr;
    input [`SEBSW_ADDR_W-1:0] a;
    input                     page_only;
    begin
      if (page_only) begin
        next_addr = {a[`SEBSW_ADDR_W-1:`SEBSW_PAGE_AW], a[`SEBSW_PAGE_AW-1:0] + 1'b1};
      end else begin
        next_addr = a + 1'b1;
      end
    end
  endfunction

  // pin synchronisers; stage three only feeds edge detection
  reg       scl_s1_q;
  reg       scl_s2_q;
  reg       scl_s3_q;
  reg       sda_s1_q;
  reg       sda_s2_q;
  reg       sda_s3_q;
  reg       wp_s1_q;
  reg       wp_s2_q;
  reg [2:0] cs_s1_q;
  reg [2:0] cs_s2_q;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      wp_s1_q  <= 1'b0;
      wp_s2_q  <= 1'b0;
      cs_s1_q  <= 3'h0;
      cs_s2_q  <= 3'h0;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      wp_s1_q  <= wp_in;
      wp_s2_q  <= wp_s1_q;
      cs_s1_q  <= {chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in};
      cs_s2_q  <= cs_s1_q;
    end
  end

  wire scl_rise  = scl_s2_q & ~scl_s3_q;
  wire scl_fall  = ~scl_s2_q & scl_s3_q;
  wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  reg [6:0]                  st_q;
  reg [`SEBSW_BIT_CNT_W-1:0] bit_cnt_q;
  reg                        ack_q;
  reg                        mslot_q;
  reg                        mack_q;
  reg                        drv_q;
  reg [7:0]                  shift_q;
  reg [7:0]                  tx_q;
  reg [`SEBSW_HI_W-1:0]      hi_q;
  reg [`SEBSW_ADDR_W-1:0]    ptr_q;
  reg                        got_data_q;
  reg [`SEBSW_PAGE_BYTES-1:0] valid_q;
  reg                        busy_q;

  wire byte_full = (bit_cnt_q == `SEBSW_BITS_BYTE);
  wire byte_done = scl_fall & byte_full & ~ack_q & ~start_det & ~stop_det;
  wire pm_we     = byte_done & (st_q == S_WDATA);
  wire prot_hit  = wp_s2_q &
                   (ptr_q[`SEBSW_PROT_MSB:`SEBSW_PROT_LSB] == `SEBSW_PROT_CODE);
  wire commit_go = stop_det & ~start_det & (st_q == S_WDATA) & got_data_q & ~prot_hit;
  wire ctrl_ok   = (shift_q[`SEBSW_TYPE_MSB:`SEBSW_TYPE_LSB] == DEV_TYPE_CODE) &
                   (shift_q[`SEBSW_CS_MSB:`SEBSW_CS_LSB] == cs_s2_q);

  // open drain: only ever pulls low
  assign sda_out     = 1'b0;
  assign sda_oe_out  = drv_q;
  assign rd_addr_out = ptr_q;
  assign busy_out    = busy_q;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_q       <= S_IDLE;
      bit_cnt_q  <= `SEBSW_BIT_ZERO;
      ack_q      <= 1'b0;
      mslot_q    <= 1'b0;
      mack_q     <= 1'b0;
      drv_q      <= 1'b0;
      shift_q    <= 8'h00;
      tx_q       <= 8'hff;
      hi_q       <= {`SEBSW_HI_W{1'b0}};
      ptr_q      <= {`SEBSW_ADDR_W{1'b0}};
      got_data_q <= 1'b0;
      valid_q    <= {`SEBSW_PAGE_BYTES{1'b0}};
    end else if (start_det) begin
      st_q      <= S_CTRL;
      bit_cnt_q <= `SEBSW_BIT_ZERO;
      ack_q     <= 1'b0;
      mslot_q   <= 1'b0;
      drv_q     <= 1'b0;
    end else if (stop_det) begin
      // a protected write simply ends here, ready for the next command
      st_q      <= S_IDLE;
      bit_cnt_q <= `SEBSW_BIT_ZERO;
      ack_q     <= 1'b0;
      mslot_q   <= 1'b0;
      drv_q     <= 1'b0;
    end else begin
      case (st_q)
        S_CTRL, S_ADRH, S_ADRL, S_WDATA: begin
          if (scl_rise & ~ack_q & ~byte_full) begin
            shift_q   <= {shift_q[6:0], sda_s2_q};
            bit_cnt_q <= bit_cnt_q + `SEBSW_BIT_ONE;
          end else if (scl_fall & ack_q) begin
            ack_q     <= 1'b0;
            drv_q     <= 1'b0;
            bit_cnt_q <= `SEBSW_BIT_ZERO;
          end else if (byte_done) begin
            if (st_q == S_CTRL) begin
              if (busy_q) begin
                st_q <= S_IGN;
              end else if (!ctrl_ok) begin
                st_q <= S_IGN;
              end else begin
                ack_q <= 1'b1;
                drv_q <= 1'b1;
                st_q  <= shift_q[`SEBSW_RW_BIT] ? S_RDATA : S_ADRH;
              end
            end else if (st_q == S_ADRH) begin
              hi_q  <= shift_q[`SEBSW_HI_W-1:0];
              ack_q <= 1'b1;
              drv_q <= 1'b1;
              st_q  <= S_ADRL;
            end else if (st_q == S_ADRL) begin
              ptr_q      <= {hi_q, shift_q};
              got_data_q <= 1'b0;
              valid_q    <= {`SEBSW_PAGE_BYTES{1'b0}};
              ack_q      <= 1'b1;
              drv_q      <= 1'b1;
              st_q       <= S_WDATA;
            end else begin
              // later bytes overwrite the same slots in arrival order
              valid_q[ptr_q[`SEBSW_PAGE_AW-1:0]] <= 1'b1;
              ptr_q      <= next_addr(ptr_q, 1'b1);
              got_data_q <= 1'b1;
              ack_q      <= 1'b1;
              drv_q      <= 1'b1;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall & ack_q) begin
            ack_q     <= 1'b0;
            tx_q      <= rd_data_in;
            drv_q     <= ~rd_data_in[7];
            bit_cnt_q <= `SEBSW_BIT_ZERO;
          end else if (scl_rise & mslot_q) begin
            mack_q <= ~sda_s2_q;
            ptr_q  <= next_addr(ptr_q, 1'b0);
          end else if (scl_fall & mslot_q) begin
            mslot_q <= 1'b0;
            if (mack_q) begin
              tx_q      <= rd_data_in;
              drv_q     <= ~rd_data_in[7];
              bit_cnt_q <= `SEBSW_BIT_ZERO;
            end else begin
              drv_q <= 1'b0;
              st_q  <= S_IGN;
            end
          end else if (scl_rise & ~byte_full) begin
            bit_cnt_q <= bit_cnt_q + `SEBSW_BIT_ONE;
          end else if (scl_fall & byte_full) begin
            drv_q   <= 1'b0;
            mslot_q <= 1'b1;
          end else if (scl_fall & (bit_cnt_q != `SEBSW_BIT_ZERO)) begin
            tx_q  <= {tx_q[6:0], 1'b1};
            drv_q <= ~tx_q[6];
          end
        end
        default: begin
          // idle or ignoring: line stays released until the next start
          drv_q <= 1'b0;
        end
      endcase
    end
  end

  // commit engine: scans the page buffer into the write stream
  reg [`SEBSW_PAGE_AW:0]  scan_q;
  reg                     ph_q;
  reg [`SEBSW_TMR_W-1:0]  tmr_q;
  reg [`SEBSW_BASE_W-1:0] base_q;

  wire [7:0] pm_rdata;
  wire       fifo_in_ready;
  wire [`SEBSW_FIFO_W-1:0] fifo_out_data;
  wire       scan_done  = scan_q[`SEBSW_PAGE_AW];
  wire [`SEBSW_PAGE_AW-1:0] scan_idx = scan_q[`SEBSW_PAGE_AW-1:0];
  wire       slot_valid = valid_q[scan_idx];
  wire       push       = busy_q & ~scan_done & ph_q & slot_valid;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      busy_q <= 1'b0;
      scan_q <= {(`SEBSW_PAGE_AW+1){1'b0}};
      ph_q   <= 1'b0;
      tmr_q  <= {`SEBSW_TMR_W{1'b0}};
      base_q <= {`SEBSW_BASE_W{1'b0}};
    end else if (commit_go) begin
      busy_q <= 1'b1;
      scan_q <= {(`SEBSW_PAGE_AW+1){1'b0}};
      ph_q   <= 1'b0;
      tmr_q  <= {`SEBSW_TMR_W{1'b0}};
      base_q <= ptr_q[`SEBSW_ADDR_W-1:`SEBSW_PAGE_AW];
    end else if (busy_q) begin
      if (tmr_q != TWC_LAST) begin
        tmr_q <= tmr_q + 1'b1;
      end
      // the cycle ends on the time limit once the buffer is handed over
      if ((tmr_q == TWC_LAST) & scan_done) begin
        busy_q <= 1'b0;
      end
      if (!scan_done) begin
        if (!ph_q) begin
          ph_q <= 1'b1;
        end else if (!slot_valid | fifo_in_ready) begin
          // a full fifo stalls the scan until the array side drains
          ph_q   <= 1'b0;
          scan_q <= scan_q + 1'b1;
        end
      end
    end
  end

  sebsw_page_mem u_page_mem (
    .clk_sys_in (clk_sys_in),
    .we_in      (pm_we),
    .waddr_in   (ptr_q[`SEBSW_PAGE_AW-1:0]),
    .wdata_in   (shift_q),
    .raddr_in   (scan_idx),
    .rdata_out  (pm_rdata)
  );

  sebsw_fifo #(
    .W     (`SEBSW_FIFO_W),
    .DEPTH (`SEBSW_FIFO_DEPTH),
    .AW    (`SEBSW_FIFO_AW)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .srst_in       (srst_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({base_q, scan_idx, pm_rdata}),
    .out_valid_out (prog_valid_out),
    .out_ready_in  (prog_ready_in),
    .out_data_out  (fifo_out_data)
  );

  assign prog_addr_out = fifo_out_data[`SEBSW_FIFO_W-1:8];
  assign prog_data_out = fifo_out_data[7:0];

endmodule // sebsw_slave

// [verilog/sebsw_defines.vh]
/*
 * sebsw_defines.vh: widths, field positions, timing figures and fixed codes of the
 * serial EEPROM bus slave write front end.
 * Assumes it is included by bare name from the design files of this block only.
 */
`ifndef SEBSW_DEFINES_VH
`define SEBSW_DEFINES_VH

// word address and page layout
`define SEBSW_ADDR_W      13
`define SEBSW_PAGE_AW     5
`define SEBSW_PAGE_BYTES  32
`define SEBSW_BASE_W      8
`define SEBSW_HI_W        5

// protected quarter: word address bits 12:11 both set (1800h-1fffh)
`define SEBSW_PROT_MSB    12
`define SEBSW_PROT_LSB    11
`define SEBSW_PROT_CODE   2'h3

// control byte fields
`define SEBSW_TYPE_MSB    7
`define SEBSW_TYPE_LSB    4
`define SEBSW_CS_MSB      3
`define SEBSW_CS_LSB      1
`define SEBSW_RW_BIT      0

// bit framing
`define SEBSW_BIT_CNT_W   4
`define SEBSW_BITS_BYTE   4'h8
`define SEBSW_BIT_ZERO    4'h0
`define SEBSW_BIT_ONE     4'h1

// write cycle timing
`define SEBSW_TWC_MS      5
`define SEBSW_CLK_HZ      10000000
`define SEBSW_MS_DIV      1000
`define SEBSW_TMR_W       24

// write stream fifo
`define SEBSW_FIFO_DEPTH  32
`define SEBSW_FIFO_AW     5
`define SEBSW_FIFO_W      21

`endif

// [verilog/sebsw_page_mem.v]
/*
 * sebsw_page_mem.v: page buffer, one byte per slot, synchronous write,
 * registered read data.
 * Assumes a single clock shared with the bus front end.
 */
`timescale 1ns/1ps
`include "sebsw_defines.vh"

module sebsw_page_mem (
  input  wire                        clk_sys_in,
  input  wire                        we_in,
  input  wire [`SEBSW_PAGE_AW-1:0]   waddr_in,
  input  wire [7:0]                  wdata_in,
  input  wire [`SEBSW_PAGE_AW-1:0]   raddr_in,
  output reg  [7:0]                  rdata_out
);

  reg [7:0] mem [0:`SEBSW_PAGE_BYTES-1];

  always @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule // sebsw_page_mem

// [verilog/sebsw_fifo.v]
/*
 * sebsw_fifo.v: synchronous fifo with valid/ready on both sides and a
 * registered head word on the output.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "sebsw_defines.vh"

module sebsw_fifo #(
  parameter W     = `SEBSW_FIFO_W,
  parameter DEPTH = `SEBSW_FIFO_DEPTH,
  parameter AW    = `SEBSW_FIFO_AW
) (
  input  wire          clk_sys_in,
  input  wire          srst_in,
  input  wire          in_valid_in,
  output wire          in_ready_out,
  input  wire [W-1:0]  in_data_in,
  output reg           out_valid_out,
  input  wire          out_ready_in,
  output reg  [W-1:0]  out_data_out
);

  localparam integer DEPTH_I  = DEPTH;
  localparam [AW:0]  FULL_CNT = DEPTH_I[AW:0];

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;

  // count excludes the head register, so full means the array itself is full
  assign in_ready_out = (cnt_q != FULL_CNT);

  wire push = in_valid_in & in_ready_out;
  wire load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_out | out_ready_in);

  always @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
    if (srst_in) begin
      wr_q          <= {AW{1'b0}};
      rd_q          <= {AW{1'b0}};
      cnt_q         <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
      out_data_out  <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (load) begin
        out_data_out  <= mem[rd_q];
        out_valid_out <= 1'b1;
        rd_q          <= rd_q + 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
      if (push & ~load) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (load & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // sebsw_fifo

// [bench/sebsw_slave_properties.sv]
/* sebsw_slave_properties.sv: port-level checker for sebsw_slave, bound below.
   Assumes one clock domain and the TWC_CYCLES value of the bound instance. */
`timescale 1ns/1ps
module sebsw_checker #(
  parameter TWC_CYCLES = 50000
) (
  input wire        clk_sys_in,
  input wire        srst_in,
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe_out,
  input wire        wp_in,
  input wire        prog_valid_out,
  input wire        prog_ready_in,
  input wire [12:0] prog_addr_out,
  input wire [7:0]  prog_data_out,
  input wire        busy_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  reg [31:0] busy_cnt_q;
  reg        wp_wc_q;
  // wp as seen when the write cycle began; later toggles must not matter
  always @(posedge clk_sys_in) begin
    busy_cnt_q <= (busy_out && !srst_in) ? busy_cnt_q + 32'h1 : 32'h0;
    if (srst_in)
      wp_wc_q <= 1'b0;
    else if (busy_out && busy_cnt_q == 32'h0)
      wp_wc_q <= wp_in;
  end
  property p_sda_low_only; sda_out == 1'b0; endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("sda driven high");
  property p_oe_still; scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3) |-> $stable(sda_oe_out);
  endproperty
  a_oe_still: assert property (p_oe_still) else $error("sda pull changed with scl high");
  property p_busy_no_ack; busy_out && $past(busy_out) |-> !$rose(sda_oe_out); endproperty
  a_busy_no_ack: assert property (p_busy_no_ack) else $error("ack during write cycle");
  property p_busy_at_stop; $rose(busy_out) |-> scl_in && sda_in && !$past(sda_in, 6); endproperty
  a_busy_at_stop: assert property (p_busy_at_stop) else $error("write cycle not started by stop");
  property p_busy_bound; busy_cnt_q <= TWC_CYCLES + 4; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("write cycle too long");
  property p_stream_hold;
    prog_valid_out && !prog_ready_in |=> prog_valid_out && $stable(prog_addr_out) && $stable(prog_data_out);
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream word lost while stalled");
  property p_stream_in_cycle; $rose(prog_valid_out) |-> busy_out; endproperty
  a_stream_in_cycle: assert property (p_stream_in_cycle) else $error("stream outside write cycle");
  property p_stream_page;
    prog_valid_out && $past(prog_valid_out && prog_ready_in) && $past(busy_out)
      |-> prog_addr_out[12:5] == $past(prog_addr_out[12:5]) && prog_addr_out[4:0] > $past(prog_addr_out[4:0]);
  endproperty
  a_stream_page: assert property (p_stream_page) else $error("stream left its page");
  property p_protect; prog_valid_out && wp_wc_q |-> prog_addr_out[12:11] != 2'h3; endproperty
  a_protect: assert property (p_protect) else $error("protected quarter written");
endmodule // sebsw_checker

bind sebsw_slave sebsw_checker #(.TWC_CYCLES(TWC_CYCLES)) u_chk (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wp_in(wp_in), .prog_valid_out(prog_valid_out),
  .prog_ready_in(prog_ready_in), .prog_addr_out(prog_addr_out), .prog_data_out(prog_data_out),
  .busy_out(busy_out));

// [bench/sebsw_bus_master.sv]
/* sebsw_bus_master.sv: behavioural two-wire bus master, 800 ns bit period.
   Assumes sda_line_in is the wired-and of all pullers with a pull-up. */
`timescale 1ns/1ps
module sebsw_bus_master (
  input  wire clk_sys_in,
  input  wire sda_line_in,
  output reg  scl_out,
  output reg  sda_rel_out
);
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // sda moves only mid-way through scl low
  task automatic send_bit(input logic b, output logic r);
    sda_rel_out <= b;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    r = sda_line_in;
    scl_out <= 1'b0;
    tick(2);
  endtask
  // long low phase first so a late ack release cannot look like a stop
  task automatic start_cond();
    sda_rel_out <= 1'b1;
    tick(4);
    scl_out <= 1'b1;
    tick(4);
    sda_rel_out <= 1'b0;
    tick(4);
    scl_out <= 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sda_rel_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_rel_out <= 1'b1;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      send_bit(d[i], r);
    send_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, r);
      d[i] = r;
    end
    send_bit(~more, r);
  endtask
endmodule // sebsw_bus_master

// [bench/tb_sebsw_slave.sv]
/* tb_sebsw_slave.sv: self-checking bench for sebsw_slave with a bus master,
   a byte array behind the read port and a stallable write stream sink.
   Assumes a short write cycle parameter so the run stays brief. */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp); \
    end \
  end
module tb_sebsw_slave;
  localparam       TWC = 200;
  localparam [3:0] TYPE_CODE = 4'h5; // arbitrary value
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wp = 1'b0;
  logic        ready_en = 1'b1;
  logic        prog_ready = 1'b0;
  logic [2:0]  cs_pins = 3'h5;
  logic [7:0]  rd_data = 8'h00;
  logic [7:0]  mem [0:8191];
  wire         scl, sda_rel, sda_drv, sda_oe, prog_valid, busy;
  wire [12:0]  rd_addr, prog_addr;
  wire [7:0]   prog_data;
  wire         sda_line = sda_rel & (~sda_oe | sda_drv);
  int          failures = 0;
  int          total_checks = 0;
  int          pops = 0;
  always #50 clk = ~clk;
  sebsw_bus_master u_master (.clk_sys_in(clk), .sda_line_in(sda_line), .scl_out(scl), .sda_rel_out(sda_rel));
  sebsw_slave #(.DEV_TYPE_CODE(TYPE_CODE), .TWC_CYCLES(TWC)) uut (
    .clk_sys_in(clk), .srst_in(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .chip_select_bit0_in(cs_pins[0]), .chip_select_bit1_in(cs_pins[1]),
    .chip_select_bit2_in(cs_pins[2]), .wp_in(wp), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
    .prog_valid_out(prog_valid), .prog_ready_in(prog_ready), .prog_addr_out(prog_addr),
    .prog_data_out(prog_data), .busy_out(busy));
  always @(posedge clk) begin
    prog_ready <= ready_en;
    rd_data <= mem[rd_addr];
    if (prog_valid && prog_ready) begin
      mem[prog_addr] <= prog_data;
      pops <= pops + 1;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic ctrl(input logic [2:0] cs, input logic rd, input logic [3:0] code, output logic ack);
    u_master.start_cond();
    u_master.put_byte({code, cs, rd}, ack);
  endtask
  task automatic write_seq(input logic [15:0] addr, input logic [7:0] d0, input int n);
    logic a;
    ctrl(cs_pins, 1'b0, TYPE_CODE, a);
    `CHK(a, 1'b1)
    u_master.put_byte(addr[15:8], a);
    `CHK(a, 1'b1)
    u_master.put_byte(addr[7:0], a);
    `CHK(a, 1'b1)
    for (int i = 0; i < n; i++) begin
      u_master.put_byte(d0 + i[7:0], a);
      `CHK(a, 1'b1)
    end
    u_master.stop_cond();
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_done();
    int n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `CHK(busy, 1'b0)
  endtask
  task automatic read_two(input logic [12:0] addr, input logic [7:0] e0, input logic [7:0] e1);
    logic       a;
    logic [7:0] d;
    write_seq({3'h0, addr}, 8'h00, 0);
    ctrl(cs_pins, 1'b1, TYPE_CODE, a);
    `CHK(a, 1'b1)
    u_master.get_byte(1'b1, d);
    `CHK(d, e0)
    u_master.get_byte(1'b0, d);
    `CHK(d, e1)
    // after the nack the line must stay released, no next byte loaded
    repeat (2) @(posedge clk);
    `CHK(sda_oe, 1'b0)
    u_master.stop_cond();
    `CHK(sda_oe, 1'b0)
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    int   k;
    logic a;
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'h3c;
    mem[0] = 8'hc3;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    // top three bits of the high address byte must be dropped
    write_seq(16'he123, 8'h5a, 1);
    `CHK(busy, 1'b1)
    `CHK(rd_addr, 13'h0124)
    ctrl(cs_pins, 1'b0, TYPE_CODE, a);
    `CHK(a, 1'b0)
    u_master.stop_cond();
    wait_done();
    `CHK(pops, 1)
    `CHK(mem[13'h0123], 8'h5a)
    read_two(13'h0123, 8'h5a, 8'h3c);
    read_two(13'h1fff, 8'h3c, 8'hc3);
    ctrl(cs_pins ^ 3'h2, 1'b0, TYPE_CODE, a);
    `CHK(a, 1'b0)
    u_master.put_byte(8'h00, a);
    `CHK(a, 1'b0)
    u_master.stop_cond();
    ctrl(cs_pins, 1'b0, TYPE_CODE ^ 4'h1, a);
    `CHK(a, 1'b0)
    u_master.stop_cond();
    // 34 bytes from slot 30 with the sink stalled: wrap and overwrite
    ready_en <= 1'b0;
    write_seq(16'h005e, 8'h80, 34);
    repeat (100) @(posedge clk);
    `CHK(prog_valid, 1'b1)
    `CHK(mem[13'h005e], 8'h3c)
    ready_en <= 1'b1;
    wait_done();
    `CHK(pops, 33)
    for (int s = 0; s < 32; s++) begin
      k = (s + 2) % 32;
      k = (k < 2) ? k + 32 : k;
      `CHK(mem[13'h0040 + s], 8'h80 + k[7:0])
    end
    `CHK(mem[13'h0060], 8'h3c)
    wp <= 1'b1;
    write_seq(16'h1805, 8'h11, 1);
    `CHK(busy, 1'b0)
    write_seq(16'h1806, 8'h22, 1);
    `CHK(pops, 33)
    `CHK(mem[13'h1805], 8'h3c)
    // wp raised only after the stop must not cancel this write
    wp <= 1'b0;
    write_seq(16'h1807, 8'h33, 1);
    wp <= 1'b1;
    wait_done();
    `CHK(mem[13'h1807], 8'h33)
    read_two(13'h1807, 8'h33, 8'h3c);
    wp <= 1'b0;
    report_and_stop();
  end
endmodule // tb_sebsw_slave
